/* logic/mrec_checker.sv */
// Request checker that selects the exception code for the serial slave
// Summary of operation
// [RULE_01] Unknown function code gives error 01H
// [RULE_02] Unknown or zero register address gives 02H
// [RULE_03] Reading the save address gives 02H
// [RULE_04] Frequency write without serial source gives 02H
// [RULE_05] Run command without serial control gives 02H
// [RULE_06] Item count below one or above two: 03H
// [RULE_07] Value out of limits gives 21H, no change
// [RULE_08] Run-locked parameter written while running gives 22H
// [RULE_09] Protected parameter write with protection set: 22H
// [RULE_10] Write to read-only address gives 22H
// [RULE_11] Save during storage fault gives 22H
// [RULE_12] Write or save in undervoltage gives 23H
// [RULE_13] Write during keypad save, reset, loss: 24H
// [RULE_14] Bad CRC16 gives 25H
// [RULE_15] Reading reserved address gives 02H
// [RULE_16] Address high byte group plus one, low parameter
// [RULE_17] Hidden group unreachable, one first-group parameter read-only
// [RULE_18] One code; CRC, function, address, count, write
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mrec_params.svh"
module mrec_checker (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_byte_valid,
	input wire mrec_pkg::mrec_byte_t rx_byte,
	input wire logic req_valid,
	input wire mrec_pkg::mrec_byte_t req_func,
	input wire mrec_pkg::mrec_word_t req_addr,
	input wire mrec_pkg::mrec_word_t req_count,
	input wire mrec_pkg::mrec_word_t req_value,
	input wire mrec_pkg::mrec_word_t req_lim_min,
	input wire mrec_pkg::mrec_word_t req_lim_max,
	input wire logic req_run_locked,
	input wire logic req_protected,
	input wire logic drive_running,
	input wire logic undervoltage,
	input wire logic storage_fault,
	input wire logic keypad_saving,
	input wire logic fault_resetting,
	input wire logic power_loss,
	output logic rsp_valid,
	output logic rsp_error,
	output mrec_pkg::mrec_byte_t rsp_code,
	output logic rsp_commit,
	output logic irq
);
	logic [11:0] src_sel_r;
	mrec_pkg::mrec_word_t param_write_protect_r;
	logic [1:0] irq_mask_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_stat_nxt;
	logic irq_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic rsp_valid_r;
	logic rsp_error_r;
	mrec_pkg::mrec_byte_t rsp_code_r;
	logic rsp_commit_r;
	mrec_pkg::mrec_word_t err_count_r;
	mrec_pkg::mrec_chk_e chk_nxt;
	mrec_pkg::mrec_word_t crc;
	logic [3:0] freq_source_primary_sel;
	logic [3:0] freq_source_secondary_sel;
	logic [3:0] run_command_source_sel;
	logic known, is_save, is_wronly, is_rdonly, is_param, is_hidden, is_ro_param;
	logic crc_ok, func_known, is_rd, is_wr, addr_bad, count_bad, mode_bad, limit_bad, busy;
	logic bus_take;

	// Frame CRC restarts after every checked request
	mrec_crc16 u_crc (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.clear(req_valid),
		.byte_valid(rx_byte_valid),
		.byte_data(rx_byte),
		.crc(crc)
	);

	mrec_addr_class u_addr (
		.addr(req_addr),
		.known(known),
		.is_save(is_save),
		.is_wronly(is_wronly),
		.is_rdonly(is_rdonly),
		.is_param(is_param),
		.is_hidden(is_hidden),
		.is_ro_param(is_ro_param)
	);

	assign freq_source_primary_sel = src_sel_r[3:0];
	assign freq_source_secondary_sel = src_sel_r[7:4];
	assign run_command_source_sel = src_sel_r[11:8];

	// Individual check terms; a frame with its CRC appended leaves a zero residue
	assign crc_ok = (crc == 16'h0000); // RULE_14
	assign func_known = (req_func == `MREC_FC_READ) || (req_func == `MREC_FC_DIAG) ||
		(req_func == `MREC_FC_WRITE); // RULE_01
	assign is_rd = (req_func == `MREC_FC_READ);
	assign is_wr = (req_func == `MREC_FC_WRITE);
	assign addr_bad = (req_addr == `MREC_ADDR_ZERO) || !known || is_hidden || // RULE_02
		(is_rd && is_save) || // RULE_03
		(is_wr && req_addr == `MREC_ADDR_FREQ &&
		freq_source_primary_sel != `MREC_SRC_COMM &&
		freq_source_secondary_sel != `MREC_SRC_COMM) || // RULE_04
		(is_wr && req_addr == `MREC_ADDR_CMD &&
		run_command_source_sel != `MREC_SRC_COMM); // RULE_05
	assign count_bad = (req_count < `MREC_COUNT_MIN) || (req_count > `MREC_COUNT_MAX); // RULE_06
	assign mode_bad = is_rdonly || is_ro_param || // RULE_10
		(is_param && drive_running && req_run_locked) || // RULE_08
		(is_param && req_protected && param_write_protect_r != 16'h0000) || // RULE_09
		(is_save && storage_fault); // RULE_11
	assign limit_bad = !is_save && ((req_value < req_lim_min) || (req_value > req_lim_max)); // RULE_07
	assign busy = keypad_saving || fault_resetting || power_loss; // RULE_13

	// Fixed priority so exactly one code is chosen; diagnostics skip address checks
	always_comb
	begin
		chk_nxt = mrec_pkg::CHK_PASS;
		if (!crc_ok)
			chk_nxt = mrec_pkg::CHK_CRC; // RULE_18
		else if (!func_known)
			chk_nxt = mrec_pkg::CHK_FUNC;
		else if (req_func == `MREC_FC_DIAG)
			chk_nxt = mrec_pkg::CHK_PASS;
		else if (addr_bad)
			chk_nxt = mrec_pkg::CHK_ADDR;
		else if (count_bad)
			chk_nxt = mrec_pkg::CHK_COUNT;
		else if (is_wr && mode_bad)
			chk_nxt = mrec_pkg::CHK_MODE;
		else if (is_wr && limit_bad)
			chk_nxt = mrec_pkg::CHK_LIMIT;
		else if (is_wr && undervoltage)
			chk_nxt = mrec_pkg::CHK_UV; // RULE_12
		else if (is_wr && busy)
			chk_nxt = mrec_pkg::CHK_BUSY; // RULE_13
	end

	function automatic mrec_pkg::mrec_byte_t chk_code(input mrec_pkg::mrec_chk_e c);
		unique case (c)
			mrec_pkg::CHK_PASS: return `MREC_ERR_NONE;
			mrec_pkg::CHK_CRC: return `MREC_ERR_CRC;
			mrec_pkg::CHK_FUNC: return `MREC_ERR_FUNC;
			mrec_pkg::CHK_ADDR: return `MREC_ERR_ADDR;
			mrec_pkg::CHK_COUNT: return `MREC_ERR_COUNT;
			mrec_pkg::CHK_MODE: return `MREC_ERR_MODE;
			mrec_pkg::CHK_LIMIT: return `MREC_ERR_LIMIT;
			mrec_pkg::CHK_UV: return `MREC_ERR_UV;
			mrec_pkg::CHK_BUSY: return `MREC_ERR_BUSY;
		endcase
	endfunction : chk_code

	// Reply registered one cycle after the request; commit only for a clean write
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rsp_valid_r <= 1'b0;
			rsp_error_r <= 1'b0;
			rsp_code_r <= `MREC_ERR_NONE;
			rsp_commit_r <= 1'b0;
		end
		else
		begin
			rsp_valid_r <= req_valid;
			if (req_valid)
			begin
				rsp_error_r <= (chk_nxt != mrec_pkg::CHK_PASS); // RULE_18
				rsp_code_r <= chk_code(chk_nxt);
				rsp_commit_r <= (chk_nxt == mrec_pkg::CHK_PASS) && is_wr; // RULE_07
			end
			else
				rsp_commit_r <= 1'b0;
		end
	end

	// Saturating count of error replies, visible to software
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			err_count_r <= 16'h0000;
		else if (req_valid && chk_nxt != mrec_pkg::CHK_PASS && err_count_r != 16'hffff)
			err_count_r <= err_count_r + 16'h0001;
	end

	// Waitrequest drops for one cycle per access; the access lands on that edge
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			wait_r <= 1'b1;
		else
			wait_r <= !(wait_r && (avs_read || avs_write));
	end
	assign bus_take = (avs_read || avs_write) && !wait_r;

	// Read data prepared while waitrequest is still high
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		unique case (avs_address)
			`MREC_REG_SRC_SEL: rdata_nxt = {20'h00000, src_sel_r};
			`MREC_REG_PROTECT: rdata_nxt = {16'h0000, param_write_protect_r};
			`MREC_REG_LAST_RSP: rdata_nxt = {err_count_r, 7'h00, rsp_error_r, rsp_code_r};
			`MREC_REG_IRQ_STAT: rdata_nxt = {30'h00000000, irq_stat_r};
			`MREC_REG_IRQ_MASK: rdata_nxt = {30'h00000000, irq_mask_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rdata_r <= 32'h0000_0000;
		else if (wait_r && avs_read)
			rdata_r <= rdata_nxt;
	end

	// Software-written configuration, byte lanes honoured
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			src_sel_r <= `MREC_SRC_SEL_RST;
			param_write_protect_r <= `MREC_PROTECT_RST;
			irq_mask_r <= `MREC_MASK_RST;
		end
		else if (bus_take && avs_write)
		begin
			if (avs_address == `MREC_REG_SRC_SEL && avs_byteenable[0])
				src_sel_r[7:0] <= avs_writedata[7:0];
			if (avs_address == `MREC_REG_SRC_SEL && avs_byteenable[1])
				src_sel_r[11:8] <= avs_writedata[11:8];
			if (avs_address == `MREC_REG_PROTECT && avs_byteenable[0])
				param_write_protect_r[7:0] <= avs_writedata[7:0];
			if (avs_address == `MREC_REG_PROTECT && avs_byteenable[1])
				param_write_protect_r[15:8] <= avs_writedata[15:8];
			if (avs_address == `MREC_REG_IRQ_MASK && avs_byteenable[0])
				irq_mask_r <= avs_writedata[1:0];
		end
	end

	// Sticky events cleared by reading; a new event in the clearing cycle survives
	always_comb
	begin
		irq_stat_nxt = irq_stat_r;
		if (bus_take && avs_read && avs_address == `MREC_REG_IRQ_STAT)
			irq_stat_nxt = 2'h0;
		if (req_valid && chk_nxt == mrec_pkg::CHK_PASS)
			irq_stat_nxt[`MREC_STAT_OK] = 1'b1;
		if (req_valid && chk_nxt != mrec_pkg::CHK_PASS)
			irq_stat_nxt[`MREC_STAT_ERR] = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_stat_r <= 2'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			irq_stat_r <= irq_stat_nxt;
			irq_r <= |(irq_stat_r & irq_mask_r); // One cycle behind the status bit
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_error = rsp_error_r;
	assign rsp_code = rsp_code_r;
	assign rsp_commit = rsp_commit_r;
	assign irq = irq_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence good_frame_s;
		req_valid && crc_ok && func_known;
	endsequence
	sequence bus_wait_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	crc_error_a: assert property (req_valid && !crc_ok |=> rsp_valid && rsp_code == 8'h25) // RULE_14
		else $error("bad crc not answered with 25h");
	func_error_a: assert property (req_valid && crc_ok && !func_known |=> rsp_code == 8'h01) // RULE_01
		else $error("unknown function not answered with 01h");
	zero_addr_a: assert property (good_frame_s ##0 is_rd && req_addr == 16'h0000 // RULE_02
		|=> rsp_error && rsp_code == 8'h02)
		else $error("zero address not answered with 02h");
	save_read_a: assert property (good_frame_s ##0 is_rd && req_addr == 16'h00ff // RULE_03
		|=> rsp_code == 8'h02)
		else $error("read of save address not refused");
	freq_src_a: assert property (good_frame_s ##0 is_wr && req_addr == 16'h0002 && // RULE_04
		src_sel_r[3:0] != 4'h5 && src_sel_r[7:4] != 4'h5 |=> rsp_code == 8'h02)
		else $error("frequency write accepted without serial source");
	count_error_a: assert property (good_frame_s ##0 is_rd && known && !addr_bad && // RULE_06
		req_count > 16'h0002 |=> rsp_code == 8'h03)
		else $error("bad count not answered with 03h");
	no_commit_a: assert property (rsp_valid && rsp_error |-> !rsp_commit) // RULE_07
		else $error("erroneous write committed");
	protect_write_a: assert property (good_frame_s ##0 is_wr && is_param && // RULE_09
		!addr_bad && !count_bad && req_protected &&
		param_write_protect_r != 16'h0000 |=> rsp_code == 8'h22)
		else $error("protected write not refused");
	undervolt_code_a: assert property (rsp_valid && rsp_code == 8'h23 |-> $past(undervoltage)) // RULE_12
		else $error("23h without undervoltage");
	bus_ack_a: assert property (bus_wait_s |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not released for exactly one cycle");
endmodule : mrec_checker

/* common/mrec_params.svh */
// Constants for the request error checker: codes, addresses, offsets, reset values
`ifndef MREC_PARAMS_SVH
`define MREC_PARAMS_SVH
// Function codes accepted by the slave
`define MREC_FC_READ 8'h03
`define MREC_FC_DIAG 8'h08
`define MREC_FC_WRITE 8'h10
// Error codes carried in an exception reply
`define MREC_ERR_NONE 8'h00
`define MREC_ERR_FUNC 8'h01
`define MREC_ERR_ADDR 8'h02
`define MREC_ERR_COUNT 8'h03
`define MREC_ERR_LIMIT 8'h21
`define MREC_ERR_MODE 8'h22
`define MREC_ERR_UV 8'h23
`define MREC_ERR_BUSY 8'h24
`define MREC_ERR_CRC 8'h25
// Register address map of the drive
`define MREC_ADDR_ZERO 16'h0000
`define MREC_ADDR_CMD 16'h0001
`define MREC_ADDR_FREQ 16'h0002
`define MREC_ADDR_WO_HI 16'h001f
`define MREC_ADDR_RO_LO 16'h0020
`define MREC_ADDR_RO_HI 16'h004c
`define MREC_ADDR_SAVE 16'h00ff
`define MREC_ADDR_RO_PARAM 16'h010b
// Holes inside the read-only monitor zone
`define MREC_ADDR_RSV_A 16'h002c
`define MREC_ADDR_RSV_B_LO 16'h002e
`define MREC_ADDR_RSV_B_HI 16'h0030
`define MREC_ADDR_RSV_C_LO 16'h003d
`define MREC_ADDR_RSV_C_HI 16'h003f
`define MREC_GRP_FIRST 8'h01
`define MREC_GRP_HIDDEN 8'h10
// Data item count limits
`define MREC_COUNT_MIN 16'h0001
`define MREC_COUNT_MAX 16'h0002
// Source selector value that means serial communication
`define MREC_SRC_COMM 4'h5
// CRC16 engine
`define MREC_CRC_INIT 16'hffff
`define MREC_CRC_POLY 16'ha001
// Avalon register byte offsets
`define MREC_REG_SRC_SEL 5'h00
`define MREC_REG_PROTECT 5'h04
`define MREC_REG_LAST_RSP 5'h08
`define MREC_REG_IRQ_STAT 5'h0c
`define MREC_REG_IRQ_MASK 5'h10
// Field positions
`define MREC_STAT_OK 0
`define MREC_STAT_ERR 1
`define MREC_LAST_ERR_BIT 8
// Reset values
`define MREC_SRC_SEL_RST 12'h000
`define MREC_PROTECT_RST 16'h0000
`define MREC_MASK_RST 2'h0
`endif

/* common/mrec_pkg.sv */
// Types shared by the request error checker modules
package mrec_pkg;
	typedef logic [7:0] mrec_byte_t;
	typedef logic [15:0] mrec_word_t;
	// Outcome of the check chain: pass, then the faults highest priority first
	typedef enum logic [3:0] {
		CHK_PASS,
		CHK_CRC,
		CHK_FUNC,
		CHK_ADDR,
		CHK_COUNT,
		CHK_MODE,
		CHK_LIMIT,
		CHK_UV,
		CHK_BUSY
	} mrec_chk_e;
endpackage : mrec_pkg

/* logic/mrec_crc16.sv */
// Running CRC16 over received frame bytes
`timescale 1ns/1ps
`include "mrec_params.svh"
module mrec_crc16 (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clear,
	input wire logic byte_valid,
	input wire mrec_pkg::mrec_byte_t byte_data,
	output mrec_pkg::mrec_word_t crc
);
	mrec_pkg::mrec_word_t crc_r;

	// One byte per clock, reflected polynomial, LSB first
	function automatic mrec_pkg::mrec_word_t crc_step(input mrec_pkg::mrec_word_t c,
		input mrec_pkg::mrec_byte_t b);
		mrec_pkg::mrec_word_t v;
		v = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			v = v[0] ? ((v >> 1) ^ `MREC_CRC_POLY) : (v >> 1);
		end
		return v;
	endfunction : crc_step

	// Clear restarts from the seed but still absorbs a byte in the same cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			crc_r <= `MREC_CRC_INIT;
		else if (clear)
			crc_r <= byte_valid ? crc_step(`MREC_CRC_INIT, byte_data) : `MREC_CRC_INIT;
		else if (byte_valid)
			crc_r <= crc_step(crc_r, byte_data);
	end

	assign crc = crc_r;
endmodule : mrec_crc16

/* logic/mrec_addr_class.sv */
// Classifies a register address into the zones of the drive map
`timescale 1ns/1ps
`include "mrec_params.svh"
module mrec_addr_class (
	input wire mrec_pkg::mrec_word_t addr,
	output logic known,
	output logic is_save,
	output logic is_wronly,
	output logic is_rdonly,
	output logic is_param,
	output logic is_hidden,
	output logic is_ro_param
);
	logic [7:0] grp_hi;
	logic [7:0] par_lo;
	logic [7:0] last_par;
	logic rd_reserved;

	// Upper byte is group plus one, lower byte the parameter number
	assign grp_hi = addr[15:8]; // RULE_16
	assign par_lo = addr[7:0]; // RULE_16

	// Highest parameter number of each group
	always_comb
	begin
		last_par = 8'h00;
		unique case (grp_hi)
			8'h01: last_par = 8'h16;
			8'h02: last_par = 8'h10;
			8'h03: last_par = 8'h22;
			8'h04: last_par = 8'h1a;
			8'h05: last_par = 8'h19;
			8'h06: last_par = 8'h24;
			8'h07: last_par = 8'h0b;
			8'h08: last_par = 8'h12;
			8'h09: last_par = 8'h06;
			8'h0a: last_par = 8'h09;
			8'h0b: last_par = 8'h09;
			8'h0c: last_par = 8'h08;
			8'h0d: last_par = 8'h16;
			8'h0e: last_par = 8'h13;
			8'h0f: last_par = 8'h0c;
			8'h10: last_par = 8'h04;
			default: last_par = 8'h00;
		endcase
	end

	// Holes inside the monitor zone read as unknown addresses
	assign rd_reserved = (addr == `MREC_ADDR_RSV_A) ||
		(addr >= `MREC_ADDR_RSV_B_LO && addr <= `MREC_ADDR_RSV_B_HI) ||
		(addr >= `MREC_ADDR_RSV_C_LO && addr <= `MREC_ADDR_RSV_C_HI); // RULE_15
	assign is_save = (addr == `MREC_ADDR_SAVE);
	assign is_wronly = (addr >= `MREC_ADDR_CMD) && (addr <= `MREC_ADDR_WO_HI);
	assign is_rdonly = (addr >= `MREC_ADDR_RO_LO) && (addr <= `MREC_ADDR_RO_HI) && !rd_reserved;
	assign is_param = (grp_hi >= `MREC_GRP_FIRST) && (grp_hi <= `MREC_GRP_HIDDEN) &&
		(par_lo <= last_par);
	assign is_hidden = is_param && (grp_hi == `MREC_GRP_HIDDEN); // RULE_17
	assign is_ro_param = (addr == `MREC_ADDR_RO_PARAM); // RULE_17
	assign known = is_save || is_wronly || is_rdonly || is_param;
endmodule : mrec_addr_class

/* dv/mrec_serial_master.sv */
// Serial master model: sends request frames with CRC16 and presents decoded fields
`timescale 1ns/1ps
module mrec_serial_master (
	input wire logic clk_sys,
	output logic rx_byte_valid,
	output mrec_pkg::mrec_byte_t rx_byte,
	output logic req_valid,
	output mrec_pkg::mrec_byte_t req_func,
	output mrec_pkg::mrec_word_t req_addr,
	output mrec_pkg::mrec_word_t req_count,
	output mrec_pkg::mrec_word_t req_value
);
	// Idle bus at time zero
	initial
	begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h5a;
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_count = 16'h0000;
		req_value = 16'h0000;
	end

	// One frame: seven bytes, CRC low then high, a gap, then the decoded request
	task automatic send(input mrec_pkg::mrec_byte_t f, input mrec_pkg::mrec_word_t a, c, v,
		input logic bad);
		logic [7:0] fr [9];
		logic [15:0] crc;
		fr = '{f, a[15:8], a[7:0], c[15:8], c[7:0], v[15:8], v[7:0], 8'h00, 8'h00};
		crc = 16'hffff;
		for (int i = 0; i < 7; i++)
		begin
			crc = crc ^ {8'h00, fr[i]};
			for (int k = 0; k < 8; k++)
				crc = crc[0] ? ((crc >> 1) ^ 16'ha001) : (crc >> 1);
		end
		crc = crc ^ {15'h0000, bad}; // Corrupted only when a scenario asks for it
		fr[7] = crc[7:0];
		fr[8] = crc[15:8];
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk_sys);
			rx_byte_valid <= 1'b1;
			rx_byte <= fr[i];
		end
		@(posedge clk_sys);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~fr[8]; // Released line shows no stale byte
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_func <= f;
		req_addr <= a;
		req_count <= c;
		req_value <= v;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		req_func <= ~f; // Fields are meaningless outside the strobe
		req_addr <= ~a;
		req_count <= ~c;
		req_value <= ~v;
	endtask : send
endmodule : mrec_serial_master

/* dv/tb.sv */
// Self-checking bench for the request error checker
`timescale 1ns/1ps
`include "mrec_params.svh"
module tb;
	typedef struct packed {
		logic [7:0] f;
		logic [15:0] a;
		logic [15:0] c;
		logic [15:0] v;
		logic [7:0] fl;
		logic [7:0] e;
	} mrec_row_s;
	logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic rx_byte_valid, req_valid, rsp_valid, rsp_error, rsp_commit, irq;
	mrec_pkg::mrec_byte_t rx_byte, req_func, rsp_code;
	mrec_pkg::mrec_word_t req_addr, req_count, req_value, req_lim_min, req_lim_max;
	logic req_run_locked, req_protected, drive_running, undervoltage;
	logic storage_fault, keypad_saving, fault_resetting, power_loss;
	int fails, comparisons, cycles;
	// Flags: loss, freset, keypad, sfault, uv, running, protected, locked; limits 0002..0010
	mrec_row_s rows [30] = '{
		'{8'h05,16'h0100,16'h0001,16'h0005,8'h00,8'h01},
		'{8'h06,16'h0100,16'h0001,16'h0005,8'h00,8'h01},
		'{8'h03,16'h0000,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h03,16'h0211,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h03,16'h002c,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h03,16'h004d,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h03,16'h00ff,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h10,16'h0002,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h10,16'h0001,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h03,16'h1002,16'h0001,16'h0005,8'h00,8'h02},
		'{8'h10,16'h010b,16'h0001,16'h0005,8'h00,8'h22},
		'{8'h03,16'h010b,16'h0001,16'h0005,8'h00,8'h00},
		'{8'h03,16'h0100,16'h0000,16'h0005,8'h00,8'h03},
		'{8'h03,16'h0100,16'h0003,16'h0005,8'h00,8'h03},
		'{8'h10,16'h0100,16'h0002,16'h0005,8'h00,8'h00},
		'{8'h10,16'h0100,16'h0001,16'h0011,8'h00,8'h21},
		'{8'h10,16'h0100,16'h0001,16'h0001,8'h00,8'h21},
		'{8'h10,16'h0100,16'h0001,16'h0010,8'h00,8'h00},
		'{8'h10,16'h0100,16'h0001,16'h0005,8'h05,8'h22},
		'{8'h10,16'h0100,16'h0001,16'h0005,8'h04,8'h00},
		'{8'h10,16'h0031,16'h0001,16'h0005,8'h00,8'h22},
		'{8'h10,16'h00ff,16'h0001,16'h0005,8'h10,8'h22},
		'{8'h10,16'h00ff,16'h0001,16'h0005,8'h08,8'h23},
		'{8'h10,16'h0100,16'h0001,16'h0005,8'h08,8'h23},
		'{8'h10,16'h0100,16'h0001,16'h0005,8'h20,8'h24},
		'{8'h10,16'h0100,16'h0001,16'h0005,8'hc0,8'h24},
		'{8'h03,16'h0f0c,16'h0002,16'h0005,8'h00,8'h00},
		'{8'h05,16'h0000,16'h0000,16'h0005,8'hff,8'h01},
		'{8'h10,16'h0031,16'h0003,16'h0005,8'h08,8'h03},
		'{8'h10,16'h0100,16'h0001,16'h0011,8'h88,8'h21}
	};

	mrec_checker mrec_checker_i (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_byte_valid,
		.rx_byte, .req_valid, .req_func, .req_addr, .req_count, .req_value, .req_lim_min,
		.req_lim_max, .req_run_locked, .req_protected, .drive_running, .undervoltage,
		.storage_fault, .keypad_saving, .fault_resetting, .power_loss, .rsp_valid,
		.rsp_error, .rsp_code, .rsp_commit, .irq);
	mrec_serial_master mrec_serial_master_i (.clk_sys, .rx_byte_valid, .rx_byte,
		.req_valid, .req_func, .req_addr, .req_count, .req_value);

	// Free-running system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic results;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			results();
		end
	end

	task automatic chk_code(input mrec_pkg::mrec_byte_t got, input mrec_pkg::mrec_byte_t exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_code

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	// One bus access; the request holds until waitrequest is sampled low
	// Only the hang guard may end the wait, so a stuck slave still reaches the verdict
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av

	// One request through the master model, then the reply is checked
	task automatic rq(input mrec_row_s r, input logic bad);
		logic [31:0] x;
		{power_loss, fault_resetting, keypad_saving, storage_fault, undervoltage,
			drive_running, req_protected, req_run_locked} <= r.fl;
		mrec_serial_master_i.send(r.f, r.a, r.c, r.v, bad);
		do
			@(posedge clk_sys);
		while (rsp_valid !== 1'b1);
		x = {29'h0, 1'b1, r.e != 8'h00, r.e == 8'h00 && r.f == 8'h10};
		chk_code(rsp_code, r.e);
		chk_word({29'h0, rsp_valid, rsp_error, rsp_commit}, x);
	endtask : rq

	// Main sequence
	initial
	begin
		nrst = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		req_lim_min = 16'h0002;
		req_lim_max = 16'h0010;
		{power_loss, fault_resetting, keypad_saving, storage_fault} = 4'h0;
		{undervoltage, drive_running, req_protected, req_run_locked} = 4'h0;
		fails = 0;
		comparisons = 0;
		cycles = 0;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		av(1'b1, 5'h14, 32'hffffffff);
		av(1'b0, 5'h14, 32'h0);
		chk_word(rd, 32'h0);
		av(1'b0, `MREC_REG_PROTECT, 32'h0);
		chk_word(rd, 32'h0);
		for (int i = 0; i < 30; i++)
			rq(rows[i], 1'b0);
		// A bad checksum outranks every other fault
		rq('{8'h03,16'h0100,16'h0001,16'h0005,8'h00,8'h25}, 1'b1);
		rq('{8'h05,16'h0000,16'h0000,16'h0005,8'h08,8'h25}, 1'b1);
		av(1'b0, `MREC_REG_LAST_RSP, 32'h0);
		// Last reply was a checksum error; 25 table errors plus two bad frames so far
		chk_word(rd, 32'h001b0125);
		// Protection blocks only protected targets, and clearing it reopens them
		av(1'b1, `MREC_REG_PROTECT, 32'h1);
		av(1'b0, `MREC_REG_PROTECT, 32'h0);
		chk_word(rd, 32'h1);
		rq('{8'h10,16'h0100,16'h0001,16'h0005,8'h02,8'h22}, 1'b0);
		rq('{8'h10,16'h0100,16'h0001,16'h0005,8'h00,8'h00}, 1'b0);
		av(1'b1, `MREC_REG_PROTECT, 32'h0);
		rq('{8'h10,16'h0100,16'h0001,16'h0005,8'h02,8'h00}, 1'b0);
		// Each source selector opens only its own address
		av(1'b1, `MREC_REG_SRC_SEL, 32'h0050);
		rq('{8'h10,16'h0002,16'h0001,16'h0005,8'h00,8'h00}, 1'b0);
		rq('{8'h10,16'h0001,16'h0001,16'h0005,8'h00,8'h02}, 1'b0);
		av(1'b1, `MREC_REG_SRC_SEL, 32'h0505);
		rq('{8'h10,16'h0002,16'h0001,16'h0005,8'h00,8'h00}, 1'b0);
		rq('{8'h10,16'h0001,16'h0001,16'h0005,8'h00,8'h00}, 1'b0);
		// Interrupt: raised by an error reply, cleared by reading, masked for ok replies
		av(1'b0, `MREC_REG_IRQ_STAT, 32'h0);
		av(1'b1, `MREC_REG_IRQ_MASK, 32'h2);
		rq('{8'h03,16'h0000,16'h0001,16'h0005,8'h00,8'h02}, 1'b0);
		@(posedge clk_sys);
		chk_word({31'h0, irq}, 32'h1);
		av(1'b0, `MREC_REG_IRQ_STAT, 32'h0);
		chk_word(rd, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk_word({31'h0, irq}, 32'h0);
		rq('{8'h08,16'h0000,16'h0000,16'h0005,8'h00,8'h00}, 1'b0);
		repeat (2) @(posedge clk_sys);
		chk_word({31'h0, irq}, 32'h0);
		av(1'b0, `MREC_REG_IRQ_STAT, 32'h0);
		chk_word(rd, 32'h1);
		// Reset in mid-run restores the selectors, so serial frequency writes are refused again
		nrst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk_code(rsp_code, 8'h00);
		nrst <= 1'b1;
		av(1'b0, `MREC_REG_SRC_SEL, 32'h0);
		chk_word(rd, 32'h0);
		rq('{8'h10,16'h0002,16'h0001,16'h0005,8'h00,8'h02}, 1'b0);
		results();
	end
endmodule : tb
